// ===== inc/pca_consts.svh
`ifndef PCA_CONSTS_SVH
`define PCA_CONSTS_SVH
// register byte offsets
`define PCA_REG_CTRL      12'h000
`define PCA_REG_RUNCYC    12'h004
`define PCA_REG_WATCH     12'h008
`define PCA_REG_REST      12'h00c
`define PCA_REG_ALMCFG    12'h010
`define PCA_REG_BATT      12'h014
`define PCA_REG_PRESS     12'h018
`define PCA_REG_TEMP      12'h01c
`define PCA_REG_CURLIM    12'h020
`define PCA_REG_SOLLIM    12'h024
`define PCA_REG_STATUS    12'h028
`define PCA_REG_CLEAR     12'h02c
`define PCA_REG_CYCCNT    12'h030
// ctrl fields
`define PCA_CTRL_RUN      0
`define PCA_CTRL_MPI      1
`define PCA_CTRL_VARSPD   2
`define PCA_CTRL_GUARD    3
// alarm config fields
`define PCA_AC_IN1_EN     0
`define PCA_AC_IN1_NO     1
`define PCA_AC_IN1_STOP   2
`define PCA_AC_IN2_EN     3
`define PCA_AC_IN2_NO     4
`define PCA_AC_REM_EN     5
`define PCA_AC_REM_NO     6
`define PCA_AC_HIP_STOP   7
`define PCA_AC_LOP_STOP   8
`define PCA_AC_PS_LSB     9
`define PCA_AC_TMP_LSB    12
// status bit positions
`define PCA_ST_WATCH      0
`define PCA_ST_IN1        1
`define PCA_ST_IN2        2
`define PCA_ST_REMOTE     3
`define PCA_ST_HIP        4
`define PCA_ST_LOP        5
`define PCA_ST_LOWBATT    6
`define PCA_ST_PSAVE      7
`define PCA_ST_OVERCUR    8
`define PCA_ST_TEMPOFF    9
`define PCA_ST_PUMP       10
`define PCA_ST_RESTING    11
`define PCA_ST_SOL_LSB    16
// timing
`define PCA_CLK_HZ        25000000
`define PCA_DEBOUNCE_US   1000
`define PCA_DEBOUNCE_CYC  ((`PCA_DEBOUNCE_US * 25) )
`define PCA_OVERCUR_MS    2000
`define PCA_OVERCUR_CYC   (`PCA_OVERCUR_MS * (`PCA_CLK_HZ / 1000))
`endif

// ===== inc/pca_pkg.sv
package pca_pkg;
  typedef enum logic [1:0] {
    PCA_OFF    = 2'b00,
    PCA_ON     = 2'b01,
    PCA_REST   = 2'b10,
    PCA_HALT   = 2'b11
  } pca_phase_t;
  typedef enum logic [2:0] {
    PCA_PS_OFF    = 3'b000,
    PCA_PS_NOTIFY = 3'b001,
    PCA_PS_MIN    = 3'b010,
    PCA_PS_NORMAL = 3'b011,
    PCA_PS_MAX    = 3'b100
  } pca_psave_t;
  typedef enum logic [1:0] {
    PCA_TC_DISABLED = 2'b00,
    PCA_TC_DISPLAY  = 2'b01,
    PCA_TC_BELOW    = 2'b10,
    PCA_TC_ABOVE    = 2'b11
  } pca_tctl_t;
endpackage

// ===== design/pca_ctrl.sv
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "pca_consts.svh"
// Overview of operation
// R1: in cycle mode count each cam rotation; run until run-cycle target.
// R2: alarm if no cycle within watch limit; restart watch on each cycle.
// R3: watch timer starts when rest ends and runs only in on phase.
// R4: after target reached hold pump off for the rest interval.
// R5: watch limit and rest interval held as hours, minutes, seconds.
// R6: operator sets watch limit longer than one full cycle.
// R7: stop-action alarm stops pump; notify-action alarm only flags it.
// R8: each alarm offers only its documented stop/notify/event actions.
// R9: contact alarm trips on high if normally open, low if closed.
// R10: remote standby on low if normally closed, high if open.
// R11: power save cuts on period to 75, 50 or 25 percent.
// R12: notify setting warns only; off setting disables power save.
// R13: enter power save when battery below power-save threshold.
// R14: battery cutoff alarm when battery below cutoff threshold; here raised only while power save is not set to off.
// R15: multi-point injection with variable speed: power save notify only.
// R16: high/low pressure alarms versus high and low limits.
// R17: temperature control disabled, display, run below or above setpoint.
// R18: sustained over-current stops pump; limit by guard setting.
// R19: failed solenoid is skipped, operation continues.
// R20: per-valve high pressure alarm, shown as notification and reported.
// R21: synchronise, debounce inputs; count each rotation on one edge.
module pca_ctrl #(
  parameter int DEBOUNCE_CYC = `PCA_DEBOUNCE_CYC,
  parameter int OVERCUR_CYC  = `PCA_OVERCUR_CYC,
  parameter int SEC_CYC      = `PCA_CLK_HZ,
  parameter int NSOL         = 8
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              cycle_switch,
  input  wire logic              contact_in1,
  input  wire logic              contact_in2,
  input  wire logic              remote_in,
  input  wire logic [15:0]       battery_mv,
  input  wire logic [15:0]       pressure_psi,
  input  wire logic [15:0]       manifold_psi,
  input  wire logic signed [7:0] temp_f,
  input  wire logic [15:0]       motor_ma,
  input  wire logic [NSOL-1:0]   sol_active,
  output logic                   pump_on,
  output logic [NSOL-1:0]        sol_enable,
  output logic                   alarm_flag
);
  import pca_pkg::*;

  // ==========================================================
  // register file
  // ==========================================================
  logic [31:0] ctrl_reg, runcyc_reg, watch_reg, rest_reg, almcfg_reg;
  logic [31:0] batt_reg, press_reg, temp_reg, curlim_reg, sollim_reg;
  logic [31:0] status;
  logic [15:0] cyc_count;
  logic        wr_en;
  logic [31:0] clr_pulse;

  function automatic logic [31:0] hms_to_sec(input logic [31:0] v);
    // packed as hours[23:16] minutes[15:8] seconds[7:0]
    hms_to_sec = 32'(v[23:16]) * 32'd3600 + 32'(v[15:8]) * 32'd60
               + 32'(v[7:0]); // R5
  endfunction

  assign wr_en = psel && penable && pwrite;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg   <= 32'h0000_0000;
      runcyc_reg <= 32'h0000_0001;
      watch_reg  <= 32'h0000_0100;
      rest_reg   <= 32'h0000_0100;
      almcfg_reg <= 32'h0000_0000;
      batt_reg   <= 32'h0000_0000;
      press_reg  <= 32'hffff_0000;
      temp_reg   <= 32'h0000_0000;
      curlim_reg <= 32'hffff_ffff;
      sollim_reg <= 32'h0000_ffff;
    end else if (wr_en) begin
      case (paddr)
        `PCA_REG_CTRL:   ctrl_reg   <= pwdata;
        `PCA_REG_RUNCYC: runcyc_reg <= pwdata;
        `PCA_REG_WATCH:  watch_reg  <= pwdata;
        `PCA_REG_REST:   rest_reg   <= pwdata;
        `PCA_REG_ALMCFG: almcfg_reg <= pwdata;
        `PCA_REG_BATT:   batt_reg   <= pwdata;
        `PCA_REG_PRESS:  press_reg  <= pwdata;
        `PCA_REG_TEMP:   temp_reg   <= pwdata;
        `PCA_REG_CURLIM: curlim_reg <= pwdata;
        `PCA_REG_SOLLIM: sollim_reg <= pwdata;
        default: ;
      endcase
    end
  end

  assign clr_pulse = (wr_en && paddr == `PCA_REG_CLEAR) ? pwdata : 32'h0;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        pslverr <= paddr > `PCA_REG_CYCCNT || paddr[1:0] != 2'b00;
        case (paddr)
          `PCA_REG_CTRL:   prdata <= ctrl_reg;
          `PCA_REG_RUNCYC: prdata <= runcyc_reg;
          `PCA_REG_WATCH:  prdata <= watch_reg;
          `PCA_REG_REST:   prdata <= rest_reg;
          `PCA_REG_ALMCFG: prdata <= almcfg_reg;
          `PCA_REG_BATT:   prdata <= batt_reg;
          `PCA_REG_PRESS:  prdata <= press_reg;
          `PCA_REG_TEMP:   prdata <= temp_reg;
          `PCA_REG_CURLIM: prdata <= curlim_reg;
          `PCA_REG_SOLLIM: prdata <= sollim_reg;
          `PCA_REG_STATUS: prdata <= status;
          `PCA_REG_CYCCNT: prdata <= {16'h0, cyc_count};
          default:         prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================
  // input synchronise and debounce
  // ==========================================================
  localparam int NIN = 4;
  logic [NIN-1:0] raw_in, sync1, sync2, clean;
  logic [NIN-1:0] clean_d;
  logic [31:0]    db_cnt [NIN];

  assign raw_in = {remote_in, contact_in2, contact_in1, cycle_switch};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= raw_in; // R21
      sync2 <= sync1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clean   <= '0;
      clean_d <= '0;
      for (int i = 0; i < NIN; i++) db_cnt[i] <= 32'd0;
    end else begin
      clean_d <= clean;
      for (int i = 0; i < NIN; i++) begin
        if (sync2[i] == clean[i]) begin
          db_cnt[i] <= 32'd0;
        end else if (db_cnt[i] >= 32'(DEBOUNCE_CYC - 1)) begin
          clean[i]  <= sync2[i]; // R21
          db_cnt[i] <= 32'd0;
        end else begin
          db_cnt[i] <= db_cnt[i] + 32'd1;
        end
      end
    end
  end

  logic cyc_evt;
  assign cyc_evt = clean[0] && !clean_d[0]; // R21

  // ==========================================================
  // alarm evaluation
  // ==========================================================
  logic       in1_trip, in2_trip, standby, hip, lop, lowbatt, psave_low;
  logic       overcur, temp_ok;
  logic [31:0] oc_cnt;
  logic [NSOL-1:0] sol_alarm;
  pca_psave_t ps_mode;
  pca_tctl_t  tmode;
  logic signed [7:0] setpoint;

  assign ps_mode  = pca_psave_t'(almcfg_reg[`PCA_AC_PS_LSB +: 3]);
  assign tmode    = pca_tctl_t'(almcfg_reg[`PCA_AC_TMP_LSB +: 2]);
  assign setpoint = temp_reg[7:0];
  // normally open trips on high, normally closed on low
  assign in1_trip = almcfg_reg[`PCA_AC_IN1_EN]
                 && (clean[1] == almcfg_reg[`PCA_AC_IN1_NO]); // R9
  assign in2_trip = almcfg_reg[`PCA_AC_IN2_EN]
                 && (clean[2] == almcfg_reg[`PCA_AC_IN2_NO]); // R9
  assign standby  = almcfg_reg[`PCA_AC_REM_EN]
                 && (clean[3] == almcfg_reg[`PCA_AC_REM_NO]); // R10
  assign hip      = pressure_psi > press_reg[31:16]; // R16
  assign lop      = pressure_psi < press_reg[15:0];  // R16
  assign psave_low = ps_mode != PCA_PS_OFF && batt_reg[15:0] != 16'h0
                  && battery_mv < batt_reg[15:0]; // R12 R13
  assign lowbatt  = ps_mode != PCA_PS_OFF
                 && battery_mv < batt_reg[31:16]; // R14
  always_comb begin
    case (tmode)
      PCA_TC_BELOW: temp_ok = temp_f < setpoint; // R17
      PCA_TC_ABOVE: temp_ok = temp_f > setpoint; // R17
      default:      temp_ok = 1'b1;
    endcase
  end

  // current limit: motor rating with guard on, else controller rating
  logic [15:0] cur_lim;
  assign cur_lim = ctrl_reg[`PCA_CTRL_GUARD] ? curlim_reg[15:0]
                                              : curlim_reg[31:16]; // R18
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      oc_cnt <= 32'd0;
    end else if (motor_ma > cur_lim) begin
      if (oc_cnt < 32'(OVERCUR_CYC)) oc_cnt <= oc_cnt + 32'd1;
    end else begin
      oc_cnt <= 32'd0;
    end
  end
  assign overcur = oc_cnt >= 32'(OVERCUR_CYC); // R18

  // ==========================================================
  // sticky alarms and status
  // ==========================================================
  logic watch_trip;
  logic st_watch, st_in1, st_in2, st_hip, st_lop, st_lowbatt, st_oc;
  logic [NSOL-1:0] st_sol;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_watch <= 1'b0;
      st_in1 <= 1'b0;
      st_in2 <= 1'b0;
      st_hip <= 1'b0;
      st_lop <= 1'b0;
      st_lowbatt <= 1'b0;
      st_oc <= 1'b0;
      st_sol <= '0;
    end else begin
      // set wins over a clear in the same cycle
      st_watch <= watch_trip || (st_watch && !clr_pulse[`PCA_ST_WATCH]);
      st_in1   <= in1_trip || (st_in1 && !clr_pulse[`PCA_ST_IN1]);
      st_in2   <= in2_trip || (st_in2 && !clr_pulse[`PCA_ST_IN2]);
      st_hip   <= hip || (st_hip && !clr_pulse[`PCA_ST_HIP]);
      st_lop   <= lop || (st_lop && !clr_pulse[`PCA_ST_LOP]);
      st_lowbatt <= lowbatt
                 || (st_lowbatt && !clr_pulse[`PCA_ST_LOWBATT]);
      st_oc    <= overcur || (st_oc && !clr_pulse[`PCA_ST_OVERCUR]);
      for (int i = 0; i < NSOL; i++)
        st_sol[i] <= (sol_active[i] && manifold_psi > sollim_reg[15:0])
                  || (st_sol[i] && !clr_pulse[`PCA_ST_SOL_LSB + i]); // R20
    end
  end

  logic stop_req;
  // R8: input 2, low battery, overcurrent and watch are stop only
  assign stop_req = st_watch || st_in2 || st_lowbatt || st_oc
                 || (st_in1 && almcfg_reg[`PCA_AC_IN1_STOP])
                 || (st_hip && almcfg_reg[`PCA_AC_HIP_STOP])
                 || (st_lop && almcfg_reg[`PCA_AC_LOP_STOP]); // R7 R8

  // ==========================================================
  // cycle mode sequencer
  // ==========================================================
  pca_phase_t phase;
  logic [31:0] sec_div, sec_cnt, on_cyc, on_lim;
  logic        sec_tick, ps_cut;

  assign sec_tick = sec_div == 32'(SEC_CYC - 1);
  // multi-point with variable speed keeps power save as notify only
  assign ps_cut = psave_low && ps_mode > PCA_PS_NOTIFY
               && !(ctrl_reg[`PCA_CTRL_MPI]
                    && ctrl_reg[`PCA_CTRL_VARSPD]); // R12 R15
  always_comb begin
    on_lim = runcyc_reg;
    if (ps_cut) begin
      case (ps_mode)
        PCA_PS_MIN:    on_lim = (runcyc_reg * 32'd3) >> 2; // R11
        PCA_PS_NORMAL: on_lim = runcyc_reg >> 1;           // R11
        PCA_PS_MAX:    on_lim = runcyc_reg >> 2;           // R11
        default:       on_lim = runcyc_reg;
      endcase
      if (on_lim == 32'd0) on_lim = 32'd1;
    end
  end

  assign watch_trip = phase == PCA_ON && sec_tick
                   && sec_cnt + 32'd1 >= hms_to_sec(watch_reg); // R2

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase     <= PCA_OFF;
      sec_div   <= 32'd0;
      sec_cnt   <= 32'd0;
      on_cyc    <= 32'd0;
      cyc_count <= 16'h0000;
    end else begin
      sec_div <= sec_tick ? 32'd0 : sec_div + 32'd1;
      if (cyc_evt) cyc_count <= cyc_count + 16'h0001;
      case (phase)
        PCA_OFF: begin
          sec_cnt <= 32'd0;
          on_cyc  <= 32'd0;
          if (ctrl_reg[`PCA_CTRL_RUN]) phase <= PCA_ON;
        end
        PCA_ON: begin
          if (!ctrl_reg[`PCA_CTRL_RUN]) begin
            phase <= PCA_OFF;
          end else if (stop_req) begin
            phase <= PCA_HALT; // R7
          end else if (cyc_evt) begin
            sec_cnt <= 32'd0; // R2
            // restart the second divider so watch and rest run full seconds
            sec_div <= 32'd0; // R2 R3 R4
            on_cyc  <= on_cyc + 32'd1; // R1
            if (on_cyc + 32'd1 >= on_lim) begin
              phase   <= PCA_REST; // R4
              on_cyc  <= 32'd0;
            end
          end else if (sec_tick) begin
            sec_cnt <= sec_cnt + 32'd1; // R3
          end
        end
        PCA_REST: begin
          if (!ctrl_reg[`PCA_CTRL_RUN]) begin
            phase <= PCA_OFF;
          end else if (sec_tick) begin
            if (sec_cnt + 32'd1 >= hms_to_sec(rest_reg)) begin
              phase   <= PCA_ON; // R3 R4
              sec_cnt <= 32'd0;
            end else begin
              sec_cnt <= sec_cnt + 32'd1;
            end
          end
        end
        PCA_HALT: begin
          sec_cnt <= 32'd0;
          if (!stop_req || !ctrl_reg[`PCA_CTRL_RUN]) phase <= PCA_OFF;
        end
        default: phase <= PCA_OFF;
      endcase
    end
  end

  assign status = {{(16-NSOL){1'b0}}, st_sol, 4'h0,
                   phase == PCA_REST, phase == PCA_ON, !temp_ok, st_oc,
                   psave_low, st_lowbatt, st_lop, st_hip, standby,
                   st_in2, st_in1, st_watch};

  // ==========================================================
  // outputs
  // ==========================================================
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pump_on    <= 1'b0;
      sol_enable <= '0;
      alarm_flag <= 1'b0;
    end else begin
      pump_on    <= phase == PCA_ON && !standby && temp_ok && !stop_req;
      sol_enable <= sol_active & ~st_sol; // R19
      alarm_flag <= |status[`PCA_ST_OVERCUR:`PCA_ST_WATCH] || |st_sol; // R20
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  sequence s_cycle_hit;
    phase == PCA_ON && cyc_evt && !stop_req && ctrl_reg[`PCA_CTRL_RUN];
  endsequence
  chk_stop_halts: assert property (@(posedge clk) disable iff (!resetn)
    phase == PCA_ON && stop_req && ctrl_reg[0] |=> phase == PCA_HALT) // R7
    else $error("stop alarm did not halt pump");
  chk_pump_off_alarm: assert property (@(posedge clk) disable iff (!resetn)
    stop_req |=> !pump_on) // R7
    else $error("pump on during stop alarm");
  chk_watch_reset: assert property (@(posedge clk) disable iff (!resetn)
    s_cycle_hit |=> sec_cnt == 32'd0) // R2
    else $error("watch timer not restarted");
  chk_cycle_count: assert property (@(posedge clk) disable iff (!resetn)
    cyc_evt |=> cyc_count == $past(cyc_count) + 16'h0001) // R1
    else $error("cycle not counted");
  chk_single_edge: assert property (@(posedge clk) disable iff (!resetn)
    cyc_evt |=> !cyc_evt) // R21
    else $error("rotation counted twice");
  chk_solenoid_skip: assert property (@(posedge clk) disable iff (!resetn)
    ##1 (sol_enable & $past(st_sol)) == '0) // R19
    else $error("failed solenoid still driven");
  chk_standby_off: assert property (@(posedge clk) disable iff (!resetn)
    standby |=> !pump_on) // R10
    else $error("pump runs in standby");
  chk_rest_no_watch: assert property (@(posedge clk) disable iff (!resetn)
    phase == PCA_REST |-> !watch_trip) // R3
    else $error("watch runs during rest");
  chk_target_rest: assert property (@(posedge clk) disable iff (!resetn)
    s_cycle_hit ##0 (on_cyc + 32'd1 >= on_lim)
    |=> phase == PCA_REST) // R4
    else $error("target reached without rest");
endmodule

// ===== bench/pca_cam_model.sv
`timescale 1ns/1ps
// ====
// cam switch: one rotation every 2*HALF clocks while the pump runs
module pca_cam_model #(
  parameter int HALF = 4
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic pump_on,
  input  wire logic stall,
  output logic      cycle_switch
);
  int cnt;

  // cam stands still when the motor is off or jammed
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 0;
      cycle_switch <= 1'b0;
    end else if (pump_on && !stall) begin
      if (cnt == HALF - 1) begin
        cnt <= 0;
        cycle_switch <= !cycle_switch;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule

// ===== bench/tb.sv
`timescale 1ns/1ps
`include "pca_consts.svh"
module tb;
  import pca_pkg::*;
  localparam int LIMIT = 60000;
  logic              clk, resetn, psel, penable, pwrite;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata;
  logic              pready, pslverr, last_err, prev_cs;
  logic              cycle_switch, contact_in1, contact_in2, remote_in;
  logic              stall, pump_on, alarm_flag;
  logic [15:0]       battery_mv, pressure_psi, manifold_psi, motor_ma;
  logic signed [7:0] temp_f;
  logic [7:0]        sol_active, sol_enable;
  int                miscompares, n_checks, cyc, n_rot;
  pca_psave_t        ps_tab [5] = '{PCA_PS_MIN, PCA_PS_NORMAL, PCA_PS_MAX,
                                    PCA_PS_NOTIFY, PCA_PS_MAX};
  int                exp_tab [5] = '{6, 4, 2, 8, 8};
  logic [31:0]       ctrl_tab [5] = '{32'h1, 32'h1, 32'h1, 32'h1, 32'h7};

  pca_ctrl #(.DEBOUNCE_CYC(2), .OVERCUR_CYC(8), .SEC_CYC(10), .NSOL(8)) u_dut (
    .clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .cycle_switch, .contact_in1, .contact_in2,
    .remote_in, .battery_mv, .pressure_psi, .manifold_psi, .temp_f,
    .motor_ma, .sol_active, .pump_on, .sol_enable, .alarm_flag
  );
  pca_cam_model #(.HALF(4)) u_cam (
    .clk, .resetn, .pump_on, .stall, .cycle_switch
  );

  // ====
  // clock, rotation monitor, watchdog
  always #20 clk = ~clk;

  always @(posedge clk) begin
    prev_cs <= cycle_switch;
    if (cycle_switch && !prev_cs && pump_on) n_rot <= n_rot + 1;
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      miscompares++;
      give_verdict();
    end
  end

  // ====
  // tasks
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic xfer(input logic [11:0] a, input logic w,
                      input logic [31:0] wd, output logic [31:0] rd_d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 16) begin
      n++;
      @(posedge clk);
    end
    rd_d = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 16) chk(32'h0, 32'h1, "bus answer timeout");
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] dummy;
    xfer(a, 1'b1, wd, dummy);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] rd_d);
    xfer(a, 1'b0, 32'h0, rd_d);
  endtask

  // poll status until the bit reaches v, then compare
  task automatic st_bit(input int b, input logic v);
    logic [31:0] d;
    int k;
    for (k = 0; k < 60; k++) begin
      rd(`PCA_REG_STATUS, d);
      if (d[b] === v) break;
    end
    chk({31'h0, d[b]}, {31'h0, v}, "status bit");
  endtask

  task automatic pump_is(input logic v);
    int k;
    for (k = 0; k < 3000 && pump_on !== v; k++) @(posedge clk);
    chk({31'h0, pump_on}, {31'h0, v}, "pump_on level");
  endtask

  // one full rest followed by one full on phase
  task automatic phase(output int rot, output int dt);
    int r0;
    int t0;
    pump_is(1'b1);
    pump_is(1'b0);
    t0 = cyc;
    pump_is(1'b1);
    dt = cyc - t0;
    r0 = n_rot;
    pump_is(1'b0);
    rot = n_rot - r0;
  endtask

  // ====
  // test sequence
  initial begin
    logic [31:0] d;
    int rot, dt, i, p;
    clk = 0; resetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0;
    pwdata = 0; contact_in1 = 0; contact_in2 = 0; remote_in = 0; stall = 0;
    battery_mv = 16'd13000; pressure_psi = 0; manifold_psi = 0; motor_ma = 0;
    temp_f = 0; sol_active = 0; miscompares = 0; n_checks = 0; cyc = 0;
    n_rot = 0; prev_cs = 0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd(`PCA_REG_STATUS, d);
    chk(d, 32'h0, "status after reset");
    rd(12'h034, d);
    chk({31'h0, last_err}, 32'h1, "unmapped error");
    chk(d, 32'h0, "unmapped data");
    wr(`PCA_REG_RUNCYC, 32'd10);
    wr(`PCA_REG_WATCH, 32'h0000_0005);
    wr(`PCA_REG_REST, 32'h0000_0100);
    wr(`PCA_REG_CTRL, 32'h1);
    phase(rot, dt);
    chk(32'(rot), 32'd10, "rotations per on phase");
    chk({31'h0, dt >= 600 && dt <= 604}, 32'h1, "rest length");
    st_bit(`PCA_ST_WATCH, 1'b0);
    rd(`PCA_REG_CYCCNT, d);
    chk(d, 32'd20, "cycle counter");
    wr(`PCA_REG_RUNCYC, 32'd8);
    wr(`PCA_REG_REST, 32'h0000_0001);
    wr(`PCA_REG_BATT, {16'd10500, 16'd12000});
    battery_mv <= 16'd11000;
    for (i = 0; i < 5; i++) begin
      wr(`PCA_REG_CTRL, ctrl_tab[i]);
      wr(`PCA_REG_ALMCFG, {20'h0, ps_tab[i], 9'h0});
      phase(rot, dt);
      chk(32'(rot), 32'(exp_tab[i]), "scaled count");
      if (i == 1) st_bit(`PCA_ST_PSAVE, 1'b1);
    end
    wr(`PCA_REG_CTRL, 32'h1);
    wr(`PCA_REG_RUNCYC, 32'd4000);
    battery_mv <= 16'd10000;
    st_bit(`PCA_ST_LOWBATT, 1'b1);
    pump_is(1'b0);
    battery_mv <= 16'd13000;
    wr(`PCA_REG_CLEAR, 32'h40);
    pump_is(1'b1);
    stall <= 1'b1;
    st_bit(`PCA_ST_WATCH, 1'b1);
    pump_is(1'b0);
    stall <= 1'b0;
    wr(`PCA_REG_WATCH, 32'h0000_0100);
    wr(`PCA_REG_CLEAR, 32'h1);
    pump_is(1'b1);
    for (p = 0; p < 2; p++) begin
      contact_in1 <= !p[0];
      contact_in2 <= !p[0];
      remote_in <= !p[0];
      repeat (8) @(posedge clk);
      wr(`PCA_REG_ALMCFG, {29'h0, 1'b0, p[0], 1'b1});
      contact_in1 <= p[0];
      st_bit(`PCA_ST_IN1, 1'b1);
      chk({31'h0, pump_on}, 32'h1, "notify keeps pump");
      contact_in1 <= !p[0];
      repeat (8) @(posedge clk);
      wr(`PCA_REG_CLEAR, 32'h2);
      st_bit(`PCA_ST_IN1, 1'b0);
      wr(`PCA_REG_ALMCFG, {29'h0, 1'b1, p[0], 1'b1});
      contact_in1 <= p[0];
      pump_is(1'b0);
      contact_in1 <= !p[0];
      repeat (8) @(posedge clk);
      wr(`PCA_REG_CLEAR, 32'h2);
      pump_is(1'b1);
      wr(`PCA_REG_ALMCFG, {27'h0, p[0], 1'b1, 3'h0});
      contact_in2 <= p[0];
      st_bit(`PCA_ST_IN2, 1'b1);
      pump_is(1'b0);
      contact_in2 <= !p[0];
      repeat (8) @(posedge clk);
      wr(`PCA_REG_CLEAR, 32'h4);
      pump_is(1'b1);
      wr(`PCA_REG_ALMCFG, {25'h0, p[0], 1'b1, 5'h0});
      remote_in <= p[0];
      st_bit(`PCA_ST_REMOTE, 1'b1);
      pump_is(1'b0);
      remote_in <= !p[0];
      pump_is(1'b1);
    end
    wr(`PCA_REG_ALMCFG, 32'h0);
    pressure_psi <= 16'd500;
    wr(`PCA_REG_PRESS, {16'd1000, 16'd100});
    pressure_psi <= 16'd1500;
    st_bit(`PCA_ST_HIP, 1'b1);
    chk({31'h0, pump_on}, 32'h1, "notify keeps pump");
    pressure_psi <= 16'd50;
    st_bit(`PCA_ST_LOP, 1'b1);
    pressure_psi <= 16'd500;
    wr(`PCA_REG_CLEAR, 32'h30);
    st_bit(`PCA_ST_HIP, 1'b0);
    wr(`PCA_REG_ALMCFG, 32'h80);
    pressure_psi <= 16'd1500;
    pump_is(1'b0);
    pressure_psi <= 16'd500;
    wr(`PCA_REG_CLEAR, 32'h10);
    pump_is(1'b1);
    wr(`PCA_REG_CURLIM, {16'd2000, 16'd500});
    wr(`PCA_REG_CTRL, 32'h9);
    motor_ma <= 16'd800;
    st_bit(`PCA_ST_OVERCUR, 1'b1);
    pump_is(1'b0);
    wr(`PCA_REG_CTRL, 32'h1);
    wr(`PCA_REG_CLEAR, 32'h100);
    repeat (40) @(posedge clk);
    st_bit(`PCA_ST_OVERCUR, 1'b0);
    pump_is(1'b1);
    motor_ma <= 16'd0;
    temp_f <= 8'sd20;
    wr(`PCA_REG_TEMP, 32'd50);
    wr(`PCA_REG_ALMCFG, {18'h0, PCA_TC_ABOVE, 12'h0});
    st_bit(`PCA_ST_TEMPOFF, 1'b1);
    pump_is(1'b0);
    wr(`PCA_REG_ALMCFG, {18'h0, PCA_TC_BELOW, 12'h0});
    st_bit(`PCA_ST_TEMPOFF, 1'b0);
    pump_is(1'b1);
    wr(`PCA_REG_ALMCFG, {18'h0, PCA_TC_DISPLAY, 12'h0});
    st_bit(`PCA_ST_TEMPOFF, 1'b0);
    wr(`PCA_REG_SOLLIM, 32'd300);
    sol_active <= 8'h04;
    manifold_psi <= 16'd400;
    st_bit(`PCA_ST_SOL_LSB + 2, 1'b1);
    manifold_psi <= 16'd100;
    sol_active <= 8'hff;
    repeat (4) @(posedge clk);
    chk({24'h0, sol_enable}, 32'h0000_00fb, "failed valve skipped");
    chk({31'h0, pump_on}, 32'h1, "pump keeps running");
    chk({31'h0, alarm_flag}, 32'h1, "valve alarm shown");
    give_verdict();
  end
endmodule
